// [hw/rvdr_regs.vh]
`ifndef RVDR_REGS_VH
`define RVDR_REGS_VH
// register addresses on the serial control interface
`define RVDR_ADDR_ROUTE 8'h2C
`define RVDR_ADDR_BLEED_LIN 8'h2D
`define RVDR_ADDR_BLEED_CNV 8'h2E
// writable bits of the converter bleed register
`define RVDR_BLEED_CNV_MASK 8'h3F
// default reset values, overridden per variant by parameters
`define RVDR_RST_ROUTE 8'h00
`define RVDR_RST_BLEED_LIN 8'h00
`define RVDR_RST_BLEED_CNV 8'h00
// route field width and positions
`define RVDR_ROUTE_W 2
`define RVDR_LIN1_LSB 0
`define RVDR_LIN2_LSB 2
`define RVDR_LIN3_LSB 4
`define RVDR_LIN4_LSB 6
`endif

// [hw/rvdr_regbank.v]
`timescale 1ns/1ps
`default_nettype none
`include "rvdr_regs.vh"

module rvdr_regbank #(
    parameter [7:0] RST_ROUTE = `RVDR_RST_ROUTE,
    parameter [7:0] RST_BLEED_LIN = `RVDR_RST_BLEED_LIN,
    parameter [7:0] RST_BLEED_CNV = `RVDR_RST_BLEED_CNV
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // register access from the serial control interface
    input wire reg_wr_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    output reg [7:0] reg_rdata_o,
    // voltage select pins
    input wire voltage_select_pin_one_i,
    input wire voltage_select_pin_two_i,
    input wire voltage_select_pin_three_i,
    input wire voltage_select_pin_four_i,
    // per-regulator voltage words, normal and alternate
    input wire [31:0] linreg_normal_voltage_reg_i,
    input wire [31:0] linreg_alternate_voltage_reg_i,
    output reg [31:0] linreg_voltage_code_o,
    output reg [3:0] default_voltage_choice_bit_o,
    // enables: [9:0] linear 10..1, [13:10] converter 4..1
    input wire [13:0] output_enabled_i,
    output reg [13:0] output_discharge_o
);
    // voltage words are taken as eight bits per regulator
    localparam WORD_W = 8;

    // host-visible registers
    reg [7:0] voltage_select_pin_routing_r;
    reg [7:0] linear_output_bleed_enables_r;
    reg [5:0] converter_output_bleed_enables_r;
    // two-stage synchroniser for the select pins
    reg [3:0] sel_meta_r;
    reg [3:0] sel_sync_r;
    // next value of the discharge controls
    reg [13:0] discharge_nxt;
    // per-lane results of the routing lanes
    wire [3:0] lane_choice;
    wire [31:0] lane_word;
    // write decode
    wire wr_route;
    wire wr_bleed_lin;
    wire wr_bleed_cnv;
    wire [7:0] cnv_wdata_masked;
    // bleed enables gathered in output bit order
    wire [13:0] bleed_all;
    wire [13:0] output_off;

    // select pins are asynchronous, two stages before any logic reads them
    always @(posedge clk_i) begin
        if (rst_i) begin
            sel_meta_r <= 4'h0;
            sel_sync_r <= 4'h0;
        end else begin
            sel_meta_r <= {voltage_select_pin_four_i, voltage_select_pin_three_i,
                           voltage_select_pin_two_i, voltage_select_pin_one_i};
            sel_sync_r <= sel_meta_r;
        end
    end

    // one strobe per register; other addresses fall through untouched
    assign wr_route = reg_wr_i && (reg_addr_i == `RVDR_ADDR_ROUTE);
    assign wr_bleed_lin = reg_wr_i && (reg_addr_i == `RVDR_ADDR_BLEED_LIN);
    assign wr_bleed_cnv = reg_wr_i && (reg_addr_i == `RVDR_ADDR_BLEED_CNV);
    // unused top bits masked off before they reach any storage
    assign cnv_wdata_masked = reg_wdata_i & `RVDR_BLEED_CNV_MASK;

    // pin routing register, four 2-bit route fields
    always @(posedge clk_i) begin
        if (rst_i) begin
            voltage_select_pin_routing_r <= RST_ROUTE;
        end else if (wr_route) begin
            voltage_select_pin_routing_r <= reg_wdata_i;
        end
    end

    // linear regulator bleed enables, bit 0 is regulator one
    always @(posedge clk_i) begin
        if (rst_i) begin
            linear_output_bleed_enables_r <= RST_BLEED_LIN;
        end else if (wr_bleed_lin) begin
            linear_output_bleed_enables_r <= reg_wdata_i;
        end
    end

    // converter and upper linear bleed enables; only six bits are stored
    always @(posedge clk_i) begin
        if (rst_i) begin
            converter_output_bleed_enables_r <= RST_BLEED_CNV[5:0];
        end else if (wr_bleed_cnv) begin
            converter_output_bleed_enables_r <= cnv_wdata_masked[5:0];
        end
    end

    // read mux, unmapped addresses read zero
    always @* begin
        case (reg_addr_i)
            `RVDR_ADDR_ROUTE: reg_rdata_o = voltage_select_pin_routing_r;
            `RVDR_ADDR_BLEED_LIN: reg_rdata_o = linear_output_bleed_enables_r;
            `RVDR_ADDR_BLEED_CNV: reg_rdata_o = {2'h0, converter_output_bleed_enables_r};
            default: reg_rdata_o = 8'h00;
        endcase
    end

    // enables laid out as the discharge outputs: linear 8..1, 10..9, converters
    assign bleed_all[7:0] = linear_output_bleed_enables_r;
    assign bleed_all[9:8] = converter_output_bleed_enables_r[1:0];
    assign bleed_all[13:10] = converter_output_bleed_enables_r[5:2];
    assign output_off = ~output_enabled_i;

    // bleed only a disabled output; a live one is never pulled down
    always @* begin
        discharge_nxt = bleed_all & output_off;
    end

    // lane for linear regulator one
    rvdr_pin_lane #(
        .WORD_W(WORD_W)
    ) rvdr_pin_lane_lin1_inst (
        .sel_sync_i(sel_sync_r),
        .route_i(voltage_select_pin_routing_r[`RVDR_LIN1_LSB +: `RVDR_ROUTE_W]),
        .normal_word_i(linreg_normal_voltage_reg_i[7:0]),
        .alternate_word_i(linreg_alternate_voltage_reg_i[7:0]),
        .choice_nxt_o(lane_choice[0]),
        .word_nxt_o(lane_word[7:0])
    );

    // lane for linear regulator two
    rvdr_pin_lane #(
        .WORD_W(WORD_W)
    ) rvdr_pin_lane_lin2_inst (
        .sel_sync_i(sel_sync_r),
        .route_i(voltage_select_pin_routing_r[`RVDR_LIN2_LSB +: `RVDR_ROUTE_W]),
        .normal_word_i(linreg_normal_voltage_reg_i[15:8]),
        .alternate_word_i(linreg_alternate_voltage_reg_i[15:8]),
        .choice_nxt_o(lane_choice[1]),
        .word_nxt_o(lane_word[15:8])
    );

    // lane for linear regulator three
    rvdr_pin_lane #(
        .WORD_W(WORD_W)
    ) rvdr_pin_lane_lin3_inst (
        .sel_sync_i(sel_sync_r),
        .route_i(voltage_select_pin_routing_r[`RVDR_LIN3_LSB +: `RVDR_ROUTE_W]),
        .normal_word_i(linreg_normal_voltage_reg_i[23:16]),
        .alternate_word_i(linreg_alternate_voltage_reg_i[23:16]),
        .choice_nxt_o(lane_choice[2]),
        .word_nxt_o(lane_word[23:16])
    );

    // lane for linear regulator four
    rvdr_pin_lane #(
        .WORD_W(WORD_W)
    ) rvdr_pin_lane_lin4_inst (
        .sel_sync_i(sel_sync_r),
        .route_i(voltage_select_pin_routing_r[`RVDR_LIN4_LSB +: `RVDR_ROUTE_W]),
        .normal_word_i(linreg_normal_voltage_reg_i[31:24]),
        .alternate_word_i(linreg_alternate_voltage_reg_i[31:24]),
        .choice_nxt_o(lane_choice[3]),
        .word_nxt_o(lane_word[31:24])
    );

    // choice bits registered; a pin edge shows three clock edges later
    always @(posedge clk_i) begin
        if (rst_i) begin
            default_voltage_choice_bit_o <= 4'h0;
        end else begin
            default_voltage_choice_bit_o <= lane_choice;
        end
    end

    // selected voltage words registered with their choice bits
    always @(posedge clk_i) begin
        if (rst_i) begin
            linreg_voltage_code_o <= 32'h0;
        end else begin
            linreg_voltage_code_o <= lane_word;
        end
    end

    // discharge controls registered; one cycle behind the enables
    always @(posedge clk_i) begin
        if (rst_i) begin
            output_discharge_o <= 14'h0;
        end else begin
            output_discharge_o <= discharge_nxt;
        end
    end
endmodule

// one routing lane: picks the select pin named by its route code
// and hands on the voltage word that pin asks for
module rvdr_pin_lane #(
    parameter WORD_W = 8
) (
    // synchronised select pins and the lane's route code
    input wire [3:0] sel_sync_i,
    input wire [1:0] route_i,
    // normal and alternate voltage words of this regulator
    input wire [WORD_W-1:0] normal_word_i,
    input wire [WORD_W-1:0] alternate_word_i,
    // next choice bit and next voltage word
    output reg choice_nxt_o,
    output reg [WORD_W-1:0] word_nxt_o
);
    // route code to pin; every code is legal, the default only keeps lint calm
    always @* begin
        case (route_i)
            2'h0: choice_nxt_o = sel_sync_i[0];
            2'h1: choice_nxt_o = sel_sync_i[1];
            2'h2: choice_nxt_o = sel_sync_i[2];
            2'h3: choice_nxt_o = sel_sync_i[3];
            default: choice_nxt_o = 1'h0;
        endcase
    end

    // choice 0 keeps the normal word, 1 takes the alternate one
    always @* begin
        if (choice_nxt_o) begin
            word_nxt_o = alternate_word_i;
        end else begin
            word_nxt_o = normal_word_i;
        end
    end
endmodule
`default_nettype wire

// [verif/rvdr_regbank_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// bleed gating, readback and pin-one routing at the ports
module rvdr_chk (input wire clk_i, rst_i, reg_wr_i, voltage_select_pin_one_i,
    input wire [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
    input wire [3:0] default_voltage_choice_bit_o,
    input wire [13:0] output_enabled_i, output_discharge_o);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // bleed register reads only count when no write lands in the same cycle
    wire d = reg_addr_i == 8'h2D && !reg_wr_i, e = reg_addr_i == 8'h2E && !reg_wr_i;
    wire w = reg_wr_i && reg_addr_i == 8'h2E, c = default_voltage_choice_bit_o[0];
    wire r = reg_addr_i == 8'h2C && reg_rdata_o[1:0] == 2'h0;
    wire [13:0] o = output_discharge_o, n = ~output_enabled_i;
    wire [7:0] q = reg_rdata_o;
    bleed_gate_a: assert property (!(|(o & $past(output_enabled_i)))) else $error("live");
    bleed_on_a: assert property (d && q[0] && n[0] |=> o[0]) else $error("lin on");
    bleed_off_a: assert property (d && !q[7] |=> !o[7]) else $error("lin off");
    conv_on_a: assert property (e && q[5] && n[13] |=> o[13]) else $error("conv on");
    unused_zero_a: assert property (e |-> q[7:6] == 2'h0) else $error("unused");
    conv_write_a: assert property (w ##1 e |-> q == ($past(reg_wdata_i) & 8'h3F))
        else $error("conv read");
    pin_rise_a: assert property ($rose(voltage_select_pin_one_i) && r |-> ##[2:3] c)
        else $error("rise");
    pin_fall_a: assert property ($fell(voltage_select_pin_one_i) && r |-> ##[2:3] !c)
        else $error("fall");
endmodule
`default_nettype wire

// [verif/rvdr_host.sv]
`timescale 1ns/1ps
`default_nettype none
// host side: strobe, address and pins all move at the falling edge
module rvdr_host (input wire clk_i, output logic reg_wr_i = 0,
    output logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, output logic [3:0] pins_o = 0);
    // address stays put so reads can follow; stale data is inverted
    task put(input [7:0] a, d, input w);
        @(negedge clk_i) {reg_wr_i, reg_addr_i, reg_wdata_i} = {w, a, d};
        @(negedge clk_i) {reg_wr_i, reg_wdata_i} = {1'b0, ~d};
    endtask
    task pin(input [3:0] v);
        @(negedge clk_i) pins_o = v;
    endtask
endmodule
`default_nettype wire

// [verif/rvdr_regbank_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module rvdr_regbank_tb;
    logic clk_i = 0, rst_i = 1;
    logic [13:0] output_enabled_i = 0;
    wire reg_wr_i;
    wire [3:0] pins_o, default_voltage_choice_bit_o;
    wire [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    wire [13:0] output_discharge_o;
    wire [31:0] linreg_voltage_code_o, linreg_normal_voltage_reg_i = 32'h44332211;
    wire [31:0] linreg_alternate_voltage_reg_i = 32'hDDCCBBAA;
    wire voltage_select_pin_one_i = pins_o[0], voltage_select_pin_two_i = pins_o[1];
    wire voltage_select_pin_three_i = pins_o[2], voltage_select_pin_four_i = pins_o[3];
    wire [35:0] sel = {default_voltage_choice_bit_o, linreg_voltage_code_o};
    int fails = 0, checked = 0;
    always #10 clk_i = ~clk_i;
    rvdr_host rvdr_host_inst (
        .clk_i(clk_i),
        .reg_wr_i(reg_wr_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .pins_o(pins_o)
    );
    rvdr_regbank rvdr_regbank_inst (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .reg_wr_i(reg_wr_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o),
        .voltage_select_pin_one_i(voltage_select_pin_one_i),
        .voltage_select_pin_two_i(voltage_select_pin_two_i),
        .voltage_select_pin_three_i(voltage_select_pin_three_i),
        .voltage_select_pin_four_i(voltage_select_pin_four_i),
        .linreg_normal_voltage_reg_i(linreg_normal_voltage_reg_i),
        .linreg_alternate_voltage_reg_i(linreg_alternate_voltage_reg_i),
        .linreg_voltage_code_o(linreg_voltage_code_o),
        .default_voltage_choice_bit_o(default_voltage_choice_bit_o),
        .output_enabled_i(output_enabled_i),
        .output_discharge_o(output_discharge_o)
    );
    task cmp(input [35:0] g, x);
        checked++;
        if (g !== x) $display("CHECK FAILED %0t %h %h", $time, g, x);
        fails += int'(g !== x);
    endtask
    // every route code on all lanes; only the routed pin moves
    task routing;
        for (int c = 0; c < 4; c++) begin
            rvdr_host_inst.put(8'h2C, {4{2'(c)}}, 1'b1);
            rvdr_host_inst.pin(4'h1 << c);
            repeat (4) @(negedge clk_i);
            cmp(sel, {4'hF, 32'hDDCCBBAA});
            rvdr_host_inst.pin(4'h0);
            repeat (4) @(negedge clk_i);
            cmp(sel, {4'h0, 32'h44332211});
        end
        // each lane on its own pin: pins one and three high
        rvdr_host_inst.put(8'h2C, 8'hE4, 1'b1);
        rvdr_host_inst.pin(4'h5);
        repeat (4) @(negedge clk_i);
        cmp(sel, {4'h5, 32'h44CC22AA});
        cmp(reg_rdata_o, 8'hE4);
    endtask
    // reset value, unused bits dropped, then bleed with outputs off and on
    task bleeding;
        rvdr_host_inst.put(8'h2E, 8'h00, 1'b0);
        cmp(reg_rdata_o, 0);
        rvdr_host_inst.put(8'h2E, 8'hFF, 1'b1);
        rvdr_host_inst.put(8'h2E, 8'h00, 1'b0);
        cmp(reg_rdata_o, 8'h3F);
        rvdr_host_inst.put(8'h2D, 8'h35, 1'b1);
        cmp(reg_rdata_o, 8'h35);
        repeat (2) @(negedge clk_i);
        cmp(output_discharge_o, 14'h3F35);
        output_enabled_i = 14'h3FFF;
        repeat (2) @(negedge clk_i);
        cmp(output_discharge_o, 0);
    endtask
    // mid-run reset puts every register back to its default
    task resetting;
        output_enabled_i = 14'h0000;
        repeat (2) @(negedge clk_i);
        cmp(output_discharge_o, 14'h3F35);
        rst_i = 1;
        @(negedge clk_i);
        rst_i = 0;
        cmp(output_discharge_o, 0);
        rvdr_host_inst.put(8'h2D, 8'h00, 1'b0);
        cmp(reg_rdata_o, 0);
        rvdr_host_inst.put(8'h2C, 8'h00, 1'b0);
        cmp(reg_rdata_o, 0);
        rvdr_host_inst.put(8'h2E, 8'h00, 1'b0);
        cmp(reg_rdata_o, 0);
    endtask
    task summarize;
        if (fails == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk_i);
        rst_i = 0;
        routing();
        bleeding();
        resetting();
        summarize();
    end
    // scenarios need well under a thousand cycles
    initial begin
        #20000;
        fails++;
        summarize();
    end
endmodule
bind rvdr_regbank rvdr_chk rvdr_chk_inst (.*);
`default_nettype wire
